// file: rtl/startup_protect_pkg.sv
// What this block does
// - Three burst options: disabled, low range 0.22V peak, high range 0.27V peak.
// - Burst entry at 0.93V low or 1.03V high; exit above 2.73V; disabled never bursts.
// - First startup presets high option, opens feedback resistor, turns selection current on.
// - Feedback level is sampled once when supply reaches turn-on threshold.
// - Below low bias disables burst, between biases low range, above high bias high range.
// - After selection option is frozen, selection current off, feedback resistor reconnected.
// - Error input above 0.2V before turn-on selects non-isolated, otherwise isolated.
// - Error amplifier drives feedback pin only in non-isolated configuration.
// - Line overvoltage holds non-switching protection until sense drops; checked in all run states.
// - Line overvoltage and over-temperature use non-switching auto restart.
// - Supply overvoltage checked in normal and burst-on only; trips odd-skip auto restart.
// - Switch forced off after 50us supply undervoltage or 55us overvoltage; undervoltage checked in run states and non-switching protection.
// - After undervoltage a new startup runs; above on threshold resumes with fresh soft start.
// - Overload past its blanking time enters odd-skip auto restart; normal mode only.
// - Over-temperature enters non-switching auto restart in normal, burst-on and burst-off.
// - Over-temperature recovers only after temperature falls 40C below trip point.
// - Every protection exit restarts with a new soft start, never latches off.
// - Burst entered after feedback below entry level for blanking time; left immediately above exit.
package startup_protect_pkg;

   // Clock rate and blanking times
   localparam int CLOCK_FREQ_MHZ            = 25;
   localparam int SUPPLY_UV_BLANK_US        = 50;
   localparam int SUPPLY_OV_BLANK_US        = 55;
   localparam int SUPPLY_UV_BLANK_CYCLES    = SUPPLY_UV_BLANK_US * CLOCK_FREQ_MHZ;
   localparam int SUPPLY_OV_BLANK_CYCLES    = SUPPLY_OV_BLANK_US * CLOCK_FREQ_MHZ;
   localparam int DEFAULT_BURST_BLANK_CYCLES = 500;
   localparam int DEFAULT_OVERLOAD_BLANK_CYCLES = 500;
   localparam int DEFAULT_ODD_SKIP_CYCLES   = 1;

   // Analog levels served by the comparators, in mV and degrees C
   localparam int BURST_OPTION_COUNT        = 3;
   localparam int BURST_PEAK_LOW_MV         = 220;
   localparam int BURST_PEAK_HIGH_MV        = 270;
   localparam int BURST_ENTRY_LOW_MV        = 930;
   localparam int BURST_ENTRY_HIGH_MV       = 1030;
   localparam int BURST_EXIT_MV             = 2730;
   localparam int SELECT_START_MV           = 4440;
   localparam int ERROR_INPUT_BIAS_MV       = 200;
   localparam int OVER_TEMP_HYST_C          = 40;

   // Positions of the comparator bits in the synchroniser vector
   localparam int SYNC_COUNT                = 16;
   localparam int IX_SUPPLY_START           = 0;
   localparam int IX_SUPPLY_ON              = 1;
   localparam int IX_SUPPLY_BELOW_OFF       = 2;
   localparam int IX_SUPPLY_OVP             = 3;
   localparam int IX_FB_OPTION_LOW          = 4;
   localparam int IX_FB_OPTION_HIGH         = 5;
   localparam int IX_ERR_BIAS               = 6;
   localparam int IX_FB_ENTRY_LOW           = 7;
   localparam int IX_FB_ENTRY_HIGH          = 8;
   localparam int IX_FB_EXIT                = 9;
   localparam int IX_FB_BURST_ON            = 10;
   localparam int IX_FB_BURST_OFF           = 11;
   localparam int IX_FB_OVERLOAD            = 12;
   localparam int IX_LINE_OVP               = 13;
   localparam int IX_TEMP_TRIP              = 14;
   localparam int IX_TEMP_RECOVER           = 15;

   typedef enum logic [1:0] {BURST_DISABLED, BURST_LOW, BURST_HIGH} option_type;

   localparam option_type OPTION_RESET      = BURST_HIGH;

   typedef enum logic [2:0] {
      ST_OFF, ST_CHARGE, ST_NORMAL, ST_BURST_ON, ST_BURST_OFF, ST_PROT_NOSW, ST_PROT_ODD
   } state_type;

   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_LINE_OV, CAUSE_SUPPLY_OV, CAUSE_SUPPLY_UV, CAUSE_OVERLOAD, CAUSE_OVER_TEMP
   } cause_type;

   typedef enum logic [1:0] {MODE_NONE, MODE_NON_SWITCH, MODE_AUTO_RESTART, MODE_ODD_SKIP} mode_type;

endpackage

// file: rtl/hold_qualifier.sv
`timescale 1ns/100ps
module hold_qualifier #(
   parameter int COUNT = 16
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Condition and qualified result
   input  wire logic cond,
   output logic      done
);
   localparam int W = $clog2(COUNT + 1);

   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } qual_type;

   qual_type r_q;
   qual_type r_d;

   always_comb begin
      r_d = r_q;
      if (!cond) begin
         r_d.count = '0;
      end else if (r_q.count != W'(COUNT)) begin
         r_d.count = r_q.count + 1'b1;
      end
      r_d.done = cond && (r_d.count == W'(COUNT));
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign done = r_q.done;
endmodule

// file: rtl/startup_select_and_protection.sv
`timescale 1ns/100ps
module startup_select_and_protection
   import startup_protect_pkg::*;
#(
   parameter int BURST_BLANK_CYCLES    = DEFAULT_BURST_BLANK_CYCLES,
   parameter int OVERLOAD_BLANK_CYCLES = DEFAULT_OVERLOAD_BLANK_CYCLES,
   parameter int ODD_SKIP_CYCLES       = DEFAULT_ODD_SKIP_CYCLES
) (
   // Clock and reset
   input  wire logic       CLOCK,
   input  wire logic       ARST_N,
   // Supply comparators
   input  wire logic       SUPPLY_ABOVE_START,
   input  wire logic       SUPPLY_ABOVE_ON,
   input  wire logic       SUPPLY_BELOW_OFF,
   input  wire logic       SUPPLY_ABOVE_OVERVOLTAGE,
   // Feedback pin comparators
   input  wire logic       FEEDBACK_ABOVE_OPTION_LOW,
   input  wire logic       FEEDBACK_ABOVE_OPTION_HIGH,
   input  wire logic       FEEDBACK_BELOW_ENTRY_LOW,
   input  wire logic       FEEDBACK_BELOW_ENTRY_HIGH,
   input  wire logic       FEEDBACK_ABOVE_EXIT,
   input  wire logic       FEEDBACK_ABOVE_BURST_ON,
   input  wire logic       FEEDBACK_BELOW_BURST_OFF,
   input  wire logic       FEEDBACK_ABOVE_OVERLOAD,
   // Error input, line sense and temperature comparators
   input  wire logic       ERROR_INPUT_ABOVE_BIAS,
   input  wire logic       LINE_SENSE_ABOVE_OVERVOLTAGE,
   input  wire logic       TEMP_ABOVE_TRIP,
   input  wire logic       TEMP_BELOW_RECOVER,
   // Power stage control
   output logic            SWITCH_ENABLE,
   output logic            SOFT_START,
   output logic [1:0]      BURST_PEAK_LIMIT,
   output logic            BURST_ACTIVE,
   output logic            BURST_SWITCHING,
   // Configuration
   output logic [1:0]      LIGHT_LOAD_BURST_OPTION,
   output logic            OPTION_DONE,
   output logic            NON_ISOLATED,
   output logic            ERROR_AMP_CONNECT,
   output logic            SELECT_CURRENT_ON,
   output logic            FEEDBACK_RESISTOR_SWITCH,
   // Protection status
   output logic [2:0]      PROTECTION_CAUSE,
   output logic [1:0]      PROTECTION_MODE
);
   localparam int SKIP_W = $clog2(ODD_SKIP_CYCLES + 1);

   typedef struct packed {
      logic [SYNC_COUNT-1:0] sync1;
      logic [SYNC_COUNT-1:0] sync2;
      state_type             state;
      option_type            option;
      logic                  option_done;
      logic                  non_isolated;
      logic                  over_temp;
      logic                  hiccup_low;
      logic [SKIP_W-1:0]     skip_count;
      cause_type             cause;
      mode_type              mode;
      logic                  switch_enable;
      logic                  soft_start;
      option_type            peak_limit;
      logic                  burst_active;
      logic                  burst_switching;
      logic                  error_amp_connect;
      logic                  select_current;
   } core_type;

   core_type r_q;
   core_type r_d;

   logic [SYNC_COUNT-1:0] raw_in;
   logic                  uv_cond;
   logic                  ov_cond;
   logic                  overload_cond;
   logic                  entry_cond;
   logic                  uv_done;
   logic                  ov_done;
   logic                  overload_done;
   logic                  entry_done;

   function automatic logic is_run(input state_type s);
      return (s == ST_NORMAL) || (s == ST_BURST_ON) || (s == ST_BURST_OFF);
   endfunction

   function automatic logic is_burst(input state_type s);
      return (s == ST_BURST_ON) || (s == ST_BURST_OFF);
   endfunction

   function automatic option_type decode_option(input logic above_low, input logic above_high);
      if (above_high) begin
         return BURST_HIGH;
      end else if (above_low) begin
         return BURST_LOW;
      end
      return BURST_DISABLED;
   endfunction

   always_comb begin
      raw_in                         = '0;
      raw_in[IX_SUPPLY_START]        = SUPPLY_ABOVE_START;
      raw_in[IX_SUPPLY_ON]           = SUPPLY_ABOVE_ON;
      raw_in[IX_SUPPLY_BELOW_OFF]    = SUPPLY_BELOW_OFF;
      raw_in[IX_SUPPLY_OVP]          = SUPPLY_ABOVE_OVERVOLTAGE;
      raw_in[IX_FB_OPTION_LOW]       = FEEDBACK_ABOVE_OPTION_LOW;
      raw_in[IX_FB_OPTION_HIGH]      = FEEDBACK_ABOVE_OPTION_HIGH;
      raw_in[IX_ERR_BIAS]            = ERROR_INPUT_ABOVE_BIAS;
      raw_in[IX_FB_ENTRY_LOW]        = FEEDBACK_BELOW_ENTRY_LOW;
      raw_in[IX_FB_ENTRY_HIGH]       = FEEDBACK_BELOW_ENTRY_HIGH;
      raw_in[IX_FB_EXIT]             = FEEDBACK_ABOVE_EXIT;
      raw_in[IX_FB_BURST_ON]         = FEEDBACK_ABOVE_BURST_ON;
      raw_in[IX_FB_BURST_OFF]        = FEEDBACK_BELOW_BURST_OFF;
      raw_in[IX_FB_OVERLOAD]         = FEEDBACK_ABOVE_OVERLOAD;
      raw_in[IX_LINE_OVP]            = LINE_SENSE_ABOVE_OVERVOLTAGE;
      raw_in[IX_TEMP_TRIP]           = TEMP_ABOVE_TRIP;
      raw_in[IX_TEMP_RECOVER]        = TEMP_BELOW_RECOVER;
   end

   // Qualifier conditions, all taken from the second synchroniser stage
   always_comb begin
      uv_cond       = r_q.sync2[IX_SUPPLY_BELOW_OFF];
      ov_cond       = r_q.sync2[IX_SUPPLY_OVP] && (r_q.state != ST_BURST_OFF);
      overload_cond = r_q.sync2[IX_FB_OVERLOAD] && (r_q.state == ST_NORMAL);
      entry_cond    = 1'b0;
      if (r_q.state == ST_NORMAL) begin
         unique case (r_q.option)
            BURST_DISABLED: entry_cond = 1'b0;
            BURST_LOW:      entry_cond = r_q.sync2[IX_FB_ENTRY_LOW];
            BURST_HIGH:     entry_cond = r_q.sync2[IX_FB_ENTRY_HIGH];
            default:        entry_cond = 1'b0;
         endcase
      end
   end

   hold_qualifier #(.COUNT(SUPPLY_UV_BLANK_CYCLES)) uv_timer (
      .clock  (CLOCK),
      .arst_n (ARST_N),
      .cond   (uv_cond),
      .done   (uv_done)
   );

   hold_qualifier #(.COUNT(SUPPLY_OV_BLANK_CYCLES)) ov_timer (
      .clock  (CLOCK),
      .arst_n (ARST_N),
      .cond   (ov_cond),
      .done   (ov_done)
   );

   hold_qualifier #(.COUNT(OVERLOAD_BLANK_CYCLES)) overload_timer (
      .clock  (CLOCK),
      .arst_n (ARST_N),
      .cond   (overload_cond),
      .done   (overload_done)
   );

   hold_qualifier #(.COUNT(BURST_BLANK_CYCLES)) entry_timer (
      .clock  (CLOCK),
      .arst_n (ARST_N),
      .cond   (entry_cond),
      .done   (entry_done)
   );

   always_comb begin
      logic line_ov;
      logic supply_on;
      logic nosw_fault;
      line_ov    = 1'b0;
      supply_on  = 1'b0;
      nosw_fault = 1'b0;
      r_d        = r_q;

      // Two-stage synchroniser for every comparator input
      r_d.sync1 = raw_in;
      r_d.sync2 = r_q.sync1;
      line_ov   = r_q.sync2[IX_LINE_OVP];
      supply_on = r_q.sync2[IX_SUPPLY_ON];

      // Over-temperature flag with hysteresis; a trip wins over recovery
      if (r_q.sync2[IX_TEMP_TRIP]) begin
         r_d.over_temp = 1'b1;
      end else if (r_q.sync2[IX_TEMP_RECOVER]) begin
         r_d.over_temp = 1'b0;
      end
      nosw_fault = line_ov || r_q.over_temp;
      r_d.soft_start = 1'b0;

      unique case (r_q.state)
         ST_OFF: begin
            if (r_q.sync2[IX_SUPPLY_START]) begin
               r_d.state = ST_CHARGE;
            end
         end
         ST_CHARGE: begin
            if (supply_on) begin
               if (!r_q.option_done) begin
                  r_d.option = decode_option(r_q.sync2[IX_FB_OPTION_LOW],
                                             r_q.sync2[IX_FB_OPTION_HIGH]);
                  r_d.non_isolated = r_q.sync2[IX_ERR_BIAS];
                  r_d.option_done  = 1'b1;
               end
               r_d.state      = ST_NORMAL;
               r_d.soft_start = 1'b1;
               r_d.cause      = CAUSE_NONE;
               r_d.mode       = MODE_NONE;
            end else if (!r_q.sync2[IX_SUPPLY_START] && !r_q.option_done) begin
               r_d.state = ST_OFF;
            end
         end
         ST_NORMAL, ST_BURST_ON, ST_BURST_OFF: begin
            if (uv_done) begin
               r_d.state = ST_CHARGE;
               r_d.cause = CAUSE_SUPPLY_UV;
               r_d.mode  = MODE_AUTO_RESTART;
            end else if (nosw_fault) begin
               r_d.state = ST_PROT_NOSW;
               r_d.cause = line_ov ? CAUSE_LINE_OV : CAUSE_OVER_TEMP;
               r_d.mode  = MODE_NON_SWITCH;
            end else if (ov_done) begin
               r_d.state      = ST_PROT_ODD;
               r_d.cause      = CAUSE_SUPPLY_OV;
               r_d.mode       = MODE_ODD_SKIP;
               r_d.hiccup_low = 1'b0;
               r_d.skip_count = '0;
            end else if (overload_done) begin
               r_d.state      = ST_PROT_ODD;
               r_d.cause      = CAUSE_OVERLOAD;
               r_d.mode       = MODE_ODD_SKIP;
               r_d.hiccup_low = 1'b0;
               r_d.skip_count = '0;
            end else if (r_q.state == ST_NORMAL) begin
               if (entry_done) begin
                  r_d.state = ST_BURST_OFF;
               end
            end else if (r_q.sync2[IX_FB_EXIT]) begin
               r_d.state = ST_NORMAL;
            end else if ((r_q.state == ST_BURST_OFF) && r_q.sync2[IX_FB_BURST_ON]) begin
               r_d.state = ST_BURST_ON;
            end else if ((r_q.state == ST_BURST_ON) && r_q.sync2[IX_FB_BURST_OFF]) begin
               r_d.state = ST_BURST_OFF;
            end
         end
         ST_PROT_NOSW: begin
            if (uv_done) begin
               r_d.state = ST_CHARGE;
               r_d.cause = CAUSE_SUPPLY_UV;
               r_d.mode  = MODE_AUTO_RESTART;
            end else if (!nosw_fault) begin
               r_d.state      = ST_NORMAL;
               r_d.soft_start = 1'b1;
               r_d.cause      = CAUSE_NONE;
               r_d.mode       = MODE_NONE;
            end else begin
               r_d.cause = line_ov ? CAUSE_LINE_OV : CAUSE_OVER_TEMP;
            end
         end
         ST_PROT_ODD: begin
            // Count supply hiccups: a fall below off then a rise above on
            if (r_q.sync2[IX_SUPPLY_BELOW_OFF]) begin
               r_d.hiccup_low = 1'b1;
            end else if (r_q.hiccup_low && supply_on) begin
               r_d.hiccup_low = 1'b0;
               if (r_q.skip_count == SKIP_W'(ODD_SKIP_CYCLES)) begin
                  r_d.state      = ST_NORMAL;
                  r_d.soft_start = 1'b1;
                  r_d.cause      = CAUSE_NONE;
                  r_d.mode       = MODE_NONE;
                  r_d.skip_count = '0;
               end else begin
                  r_d.skip_count = r_q.skip_count + 1'b1;
               end
            end
         end
         default: begin
            r_d.state = ST_OFF;
         end
      endcase

      if (r_d.soft_start && nosw_fault) begin
         r_d.state      = ST_PROT_NOSW;
         r_d.soft_start = 1'b0;
         r_d.cause      = line_ov ? CAUSE_LINE_OV : CAUSE_OVER_TEMP;
         r_d.mode       = MODE_NON_SWITCH;
      end

      // Registered outputs follow the next state
      r_d.switch_enable     = (r_d.state == ST_NORMAL) || (r_d.state == ST_BURST_ON);
      r_d.burst_active      = is_burst(r_d.state);
      r_d.burst_switching   = (r_d.state == ST_BURST_ON);
      r_d.peak_limit        = is_burst(r_d.state) ? r_d.option : BURST_DISABLED;
      r_d.select_current    = (r_d.state == ST_CHARGE) && !r_d.option_done;
      r_d.error_amp_connect = r_d.non_isolated && r_d.option_done && is_run(r_d.state);
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_q        <= '0;
         r_q.state  <= ST_OFF;
         r_q.option <= OPTION_RESET;
         r_q.cause  <= CAUSE_NONE;
         r_q.mode   <= MODE_NONE;
      end else begin
         r_q <= r_d;
      end
   end

   assign SWITCH_ENABLE            = r_q.switch_enable;
   assign SOFT_START               = r_q.soft_start;
   assign BURST_PEAK_LIMIT         = r_q.peak_limit;
   assign BURST_ACTIVE             = r_q.burst_active;
   assign BURST_SWITCHING          = r_q.burst_switching;
   assign LIGHT_LOAD_BURST_OPTION  = r_q.option;
   assign OPTION_DONE              = r_q.option_done;
   assign NON_ISOLATED             = r_q.non_isolated;
   assign ERROR_AMP_CONNECT        = r_q.error_amp_connect;
   assign SELECT_CURRENT_ON        = r_q.select_current;
   assign FEEDBACK_RESISTOR_SWITCH = !r_q.select_current;
   assign PROTECTION_CAUSE         = r_q.cause;
   assign PROTECTION_MODE          = r_q.mode;
endmodule

// file: tb/analog_front.sv
`timescale 1ns/100ps
module analog_front
   import startup_protect_pkg::*;
#(
   parameter int ON_MV    = 15000,
   parameter int OFF_MV   = 10000,
   parameter int OVP_MV   = 25000,
   parameter int BIAS1_MV = 1000,
   parameter int BIAS2_MV = 2000,
   parameter int BON_MV   = 2000,
   parameter int BOFF_MV  = 1200,
   parameter int OLP_MV   = 3300,
   parameter int LINE_OVERVOLTAGE_PROTECTION_MV  = 2500,
   parameter int TRIP_C   = 140
) (
   // Analog levels in mV and degrees C
   input  int                    vcc_mv,
   input  int                    fb_mv,
   input  int                    err_mv,
   input  int                    line_mv,
   input  int                    temp_c,
   // Comparator results in synchroniser order
   output logic [SYNC_COUNT-1:0] cmp
);
   assign cmp[IX_SUPPLY_START]     = vcc_mv > SELECT_START_MV;
   assign cmp[IX_SUPPLY_ON]        = vcc_mv > ON_MV;
   assign cmp[IX_SUPPLY_BELOW_OFF] = vcc_mv < OFF_MV;
   assign cmp[IX_SUPPLY_OVP]       = vcc_mv > OVP_MV;
   assign cmp[IX_FB_OPTION_LOW]    = fb_mv > BIAS1_MV;
   assign cmp[IX_FB_OPTION_HIGH]   = fb_mv > BIAS2_MV;
   assign cmp[IX_ERR_BIAS]         = err_mv > ERROR_INPUT_BIAS_MV;
   assign cmp[IX_FB_ENTRY_LOW]     = fb_mv < BURST_ENTRY_LOW_MV;
   assign cmp[IX_FB_ENTRY_HIGH]    = fb_mv < BURST_ENTRY_HIGH_MV;
   assign cmp[IX_FB_EXIT]          = fb_mv > BURST_EXIT_MV;
   assign cmp[IX_FB_BURST_ON]      = fb_mv > BON_MV;
   assign cmp[IX_FB_BURST_OFF]     = fb_mv < BOFF_MV;
   assign cmp[IX_FB_OVERLOAD]      = fb_mv > OLP_MV;
   assign cmp[IX_LINE_OVP]         = line_mv > LINE_OVERVOLTAGE_PROTECTION_MV;
   assign cmp[IX_TEMP_TRIP]        = temp_c > TRIP_C;
   assign cmp[IX_TEMP_RECOVER]     = temp_c < TRIP_C - OVER_TEMP_HYST_C;
endmodule

// file: tb/startup_protect_sva.sv
`timescale 1ns/100ps
module startup_protect_sva
   import startup_protect_pkg::*;
(
   // Clock, reset and comparators
   input wire logic       CLOCK,
   input wire logic       ARST_N,
   input wire logic       LINE_SENSE_ABOVE_OVERVOLTAGE,
   input wire logic       TEMP_ABOVE_TRIP,
   input wire logic       TEMP_BELOW_RECOVER,
   input wire logic       SUPPLY_BELOW_OFF,
   input wire logic       FEEDBACK_ABOVE_EXIT,
   // Outputs under watch
   input wire logic       SWITCH_ENABLE,
   input wire logic       SOFT_START,
   input wire logic [1:0] BURST_PEAK_LIMIT,
   input wire logic       BURST_ACTIVE,
   input wire logic [1:0] LIGHT_LOAD_BURST_OPTION,
   input wire logic       OPTION_DONE,
   input wire logic       NON_ISOLATED,
   input wire logic       ERROR_AMP_CONNECT,
   input wire logic       SELECT_CURRENT_ON,
   input wire logic       FEEDBACK_RESISTOR_SWITCH,
   input wire logic [2:0] PROTECTION_CAUSE,
   input wire logic [1:0] PROTECTION_MODE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   logic [11:0] uv_q;
   // Consecutive samples with the supply below its off level
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) uv_q <= 12'h000;
      else if (!SUPPLY_BELOW_OFF) uv_q <= 12'h000;
      else if (uv_q != 12'hFFF) uv_q <= uv_q + 12'h001;
   end
   a_line_ov_stop: assert property (LINE_SENSE_ABOVE_OVERVOLTAGE [*3] |=> !SWITCH_ENABLE && !SOFT_START)
      else $error("switch active during line overvoltage");
   a_temp_stop: assert property (TEMP_ABOVE_TRIP [*4] |=> !SWITCH_ENABLE)
      else $error("switch active during over temperature");
   a_temp_hyst: assert property (((!TEMP_BELOW_RECOVER && !SUPPLY_BELOW_OFF && !LINE_SENSE_ABOVE_OVERVOLTAGE) [*4]
      ##0 PROTECTION_CAUSE == CAUSE_OVER_TEMP) |=> PROTECTION_CAUSE == CAUSE_OVER_TEMP)
      else $error("over temperature left before hysteresis");
   a_nosw_mode: assert property (PROTECTION_CAUSE inside {CAUSE_LINE_OV, CAUSE_OVER_TEMP}
      |-> PROTECTION_MODE == MODE_NON_SWITCH && !SWITCH_ENABLE)
      else $error("wrong mode for non switching fault");
   a_odd_mode: assert property (PROTECTION_CAUSE inside {CAUSE_SUPPLY_OV, CAUSE_OVERLOAD}
      |-> PROTECTION_MODE == MODE_ODD_SKIP)
      else $error("wrong mode for odd skip fault");
   a_soft_once: assert property (SOFT_START |-> SWITCH_ENABLE ##1 !SOFT_START)
      else $error("soft start pulse malformed");
   a_option_hold: assert property (OPTION_DONE |=> OPTION_DONE && $stable(LIGHT_LOAD_BURST_OPTION) && $stable(NON_ISOLATED))
      else $error("option changed after selection");
   a_select_pins: assert property ((SELECT_CURRENT_ON != FEEDBACK_RESISTOR_SWITCH) && !(SELECT_CURRENT_ON && OPTION_DONE))
      else $error("selection current and resistor disagree");
   a_amp_connect: assert property (ERROR_AMP_CONNECT |-> NON_ISOLATED && OPTION_DONE)
      else $error("error amplifier connected when isolated");
   a_peak_limit: assert property (BURST_PEAK_LIMIT == (BURST_ACTIVE ? LIGHT_LOAD_BURST_OPTION : 2'h0)
      && !(BURST_ACTIVE && LIGHT_LOAD_BURST_OPTION == BURST_DISABLED))
      else $error("burst peak limit wrong");
   a_burst_exit: assert property (FEEDBACK_ABOVE_EXIT [*3] |=> !BURST_ACTIVE)
      else $error("burst kept above exit level");
   a_uv_off: assert property (uv_q > SUPPLY_UV_BLANK_CYCLES + 6 |-> !SWITCH_ENABLE)
      else $error("switch active after supply undervoltage");
endmodule
bind startup_select_and_protection startup_protect_sva CHK (.*);

// file: tb/startup_select_and_protection_bench.sv
`timescale 1ns/100ps
module startup_select_and_protection_bench;
   import startup_protect_pkg::*;
   logic                  CLOCK;
   logic                  ARST_N;
   int                    vcc, fb, err, line, temp, n_errors, total_checks;
   logic [SYNC_COUNT-1:0] cmp;
   logic                  sw, ss, ba, bs, od, ni, eac, sc, frs;
   logic [1:0]            bpl, opt, mode;
   logic [2:0]            cause;

   analog_front FRONT (.vcc_mv(vcc), .fb_mv(fb), .err_mv(err), .line_mv(line), .temp_c(temp), .cmp(cmp));
   startup_select_and_protection #(.BURST_BLANK_CYCLES(4), .OVERLOAD_BLANK_CYCLES(4), .ODD_SKIP_CYCLES(1)) DUT (
      .CLOCK(CLOCK), .ARST_N(ARST_N),
      .SUPPLY_ABOVE_START(cmp[IX_SUPPLY_START]), .SUPPLY_ABOVE_ON(cmp[IX_SUPPLY_ON]),
      .SUPPLY_BELOW_OFF(cmp[IX_SUPPLY_BELOW_OFF]), .SUPPLY_ABOVE_OVERVOLTAGE(cmp[IX_SUPPLY_OVP]),
      .FEEDBACK_ABOVE_OPTION_LOW(cmp[IX_FB_OPTION_LOW]), .FEEDBACK_ABOVE_OPTION_HIGH(cmp[IX_FB_OPTION_HIGH]),
      .FEEDBACK_BELOW_ENTRY_LOW(cmp[IX_FB_ENTRY_LOW]), .FEEDBACK_BELOW_ENTRY_HIGH(cmp[IX_FB_ENTRY_HIGH]),
      .FEEDBACK_ABOVE_EXIT(cmp[IX_FB_EXIT]), .FEEDBACK_ABOVE_BURST_ON(cmp[IX_FB_BURST_ON]),
      .FEEDBACK_BELOW_BURST_OFF(cmp[IX_FB_BURST_OFF]), .FEEDBACK_ABOVE_OVERLOAD(cmp[IX_FB_OVERLOAD]),
      .ERROR_INPUT_ABOVE_BIAS(cmp[IX_ERR_BIAS]), .LINE_SENSE_ABOVE_OVERVOLTAGE(cmp[IX_LINE_OVP]),
      .TEMP_ABOVE_TRIP(cmp[IX_TEMP_TRIP]), .TEMP_BELOW_RECOVER(cmp[IX_TEMP_RECOVER]),
      .SWITCH_ENABLE(sw), .SOFT_START(ss), .BURST_PEAK_LIMIT(bpl), .BURST_ACTIVE(ba), .BURST_SWITCHING(bs),
      .LIGHT_LOAD_BURST_OPTION(opt), .OPTION_DONE(od), .NON_ISOLATED(ni), .ERROR_AMP_CONNECT(eac),
      .SELECT_CURRENT_ON(sc), .FEEDBACK_RESISTOR_SWITCH(frs), .PROTECTION_CAUSE(cause), .PROTECTION_MODE(mode));

   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end

   task cyc(int n);
      repeat (n) @(negedge CLOCK);
   endtask

   task chk(string name, logic [2:0] exp, logic [2:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reset, charge and turn on
   task power_up(int fb_sel, int err_v);
      ARST_N = 1'b0;
      {vcc, fb, err, line, temp} = {32'sd0, fb_sel, err_v, 32'sd0, 32'sd25};
      cyc(3);
      ARST_N = 1'b1;
      chk("option", BURST_HIGH, opt);
      chk("resistor", 3'h1, frs);
      chk("switch", 3'h0, sw);
      chk("done", 3'h0, od);
      vcc = 5000;
      cyc(5);
      chk("select", 3'h1, sc);
      chk("resistor", 3'h0, frs);
      vcc = 20000;
      cyc(3);
      chk("soft", 3'h1, ss);
      chk("select", 3'h0, sc);
      chk("done", 3'h1, od);
      chk("resistor", 3'h1, frs);
      cyc(1);
      chk("soft", 3'h0, ss);
   endtask

   task t_options;
      for (int i = 0; i < BURST_OPTION_COUNT; i++) begin
         power_up(i * 1000 + 500, (i == 1) ? 300 : 100);
         chk("option", i[2:0], opt);
         chk("isolation", (i == 1) ? 3'h1 : 3'h0, ni);
         chk("amp", (i == 1) ? 3'h1 : 3'h0, eac);
         fb = 800;
         cyc(20);
         chk("option", i[2:0], opt);
         chk("burst", (i != 0) ? 3'h1 : 3'h0, ba);
         chk("peak", i[2:0], bpl);
         fb = 2200;
         cyc(5);
         chk("burst on", (i != 0) ? 3'h1 : 3'h0, bs);
         fb = 2800;
         cyc(5);
         chk("burst", 3'h0, ba);
         chk("peak", 3'h0, bpl);
      end
      $display("options done");
   endtask

   task t_line_temp;
      line = 3000;
      cyc(5);
      chk("switch", 3'h0, sw);
      chk("cause", CAUSE_LINE_OV, cause);
      chk("mode", MODE_NON_SWITCH, mode);
      line = 0;
      cyc(3);
      chk("soft", 3'h1, ss);
      temp = 150;
      cyc(6);
      chk("cause", CAUSE_OVER_TEMP, cause);
      chk("mode", MODE_NON_SWITCH, mode);
      temp = 120;
      cyc(10);
      chk("cause", CAUSE_OVER_TEMP, cause);
      temp = 90;
      cyc(8);
      chk("switch", 3'h1, sw);
      chk("cause", CAUSE_NONE, cause);
      $display("line and temperature done");
   endtask

   task t_undervoltage;
      vcc = 8000;
      cyc(SUPPLY_UV_BLANK_CYCLES - 10);
      vcc = 20000;
      cyc(5);
      chk("switch", 3'h1, sw);
      vcc = 8000;
      cyc(SUPPLY_UV_BLANK_CYCLES + 8);
      chk("switch", 3'h0, sw);
      chk("cause", CAUSE_SUPPLY_UV, cause);
      chk("mode", MODE_AUTO_RESTART, mode);
      vcc = 20000;
      cyc(3);
      chk("soft", 3'h1, ss);
      $display("undervoltage done");
   endtask

   // Timed fault, then two supply hiccups
   task t_odd_skip(int fb_v, int vcc_v, int n, logic [2:0] exp);
      {fb, vcc} = {fb_v, vcc_v};
      cyc(n);
      chk("switch", 3'h0, sw);
      chk("cause", exp, cause);
      chk("mode", MODE_ODD_SKIP, mode);
      fb = 1500;
      for (int k = 0; k < 2; k++) begin
         vcc = 8000;
         cyc(SUPPLY_UV_BLANK_CYCLES + 8);
         vcc = 20000;
         cyc(10);
         chk("switch", (k == 1) ? 3'h1 : 3'h0, sw);
      end
      $display("odd skip done");
   endtask

   task t_ov_in_burst;
      fb = 800;
      cyc(20);
      vcc = 30000;
      cyc(SUPPLY_OV_BLANK_CYCLES + 8);
      chk("cause", CAUSE_NONE, cause);
      $display("overvoltage in burst done");
   endtask

   initial begin
      n_errors = 0;
      total_checks = 0;
      t_options;
      t_line_temp;
      t_undervoltage;
      t_odd_skip(3500, 20000, 15, CAUSE_OVERLOAD);
      t_ov_in_burst;
      t_odd_skip(2800, 30000, SUPPLY_OV_BLANK_CYCLES + 8, CAUSE_SUPPLY_OV);
      end_of_test;
   end

   initial begin
      #1600000;
      n_errors++;
      $display("Error watchdog expected finish seen timeout");
      end_of_test;
   end
endmodule
